// >>> logic/rtpg_top.v
// Ringer tone PWM generator: register file on Avalon-MM, 768 kHz tick
// source, two tone channels and the mix toward the speakerphone driver.
// Assumes all inputs are synchronous to ref_clk at 125 MHz.
`timescale 1ns/1ps
`include "rtpg_regs.vh"

// Functional notes
// - Two independent tone channels, both mixed to speaker output during ring.
// - Each channel has 32 volume levels in control bits 4 to 0.
// - Volume zero mutes the channel whatever its enable.
// - Tone is 12.288 MHz / 16 / 32 / N, N from 1 to 256.
// - Frequency value F gives 768 kHz / (32 * (F + 1)).
// - Clock register bit 7 runs or stops the tone clock.
// - Channel enable bit updates only while the clock enable is set.
// - Control bit 7 enables the channel's tone output.
module rtpg_top (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        resetn,
    // Avalon-MM register slave
    input  wire [13:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Call state
    input  wire        ring_on,
    // Tone outputs
    output wire        tone1_pwm,
    output wire        tone2_pwm,
    output reg  [1:0]  tone_mix
);

    // ======================================================================
    // Constants
    // ======================================================================
    // Integer rates are cut to the accumulator width on purpose; both fit
    localparam integer           NCO_INC_I  = `RTPG_TICK_HZ;
    localparam integer           NCO_WRAP_I = `RTPG_SYS_HZ;
    localparam [`RTPG_NCO_W-1:0] NCO_INC    = NCO_INC_I[`RTPG_NCO_W-1:0];
    localparam [`RTPG_NCO_W-1:0] NCO_WRAP   = NCO_WRAP_I[`RTPG_NCO_W-1:0];

    // Bus handshake states, one-hot
    localparam [1:0]             BUS_IDLE   = 2'b01;
    localparam [1:0]             BUS_ACK    = 2'b10;

    // ======================================================================
    // Functions
    // ======================================================================
    // Byte address hits a register index
    function hit;
        input [13:0] addr;
        input [11:0] idx;
        begin
            hit = (addr == {idx, 2'b00});
        end
    endfunction

    // Control readback, reserved bits as zero
    function [7:0] ctl_view;
        input       en;
        input [4:0] vol;
        begin
            ctl_view = {en, 2'b00, vol};
        end
    endfunction

    // ======================================================================
    // Registers and state
    // ======================================================================
    reg                     clk_on_reg;
    reg                     ch1_en_reg;
    reg  [4:0]              ch1_vol_reg;
    reg  [7:0]              channel1_divisor_reg;
    reg                     ch2_en_reg;
    reg  [4:0]              ch2_vol_reg;
    reg  [7:0]              channel2_divisor_reg;
    reg  [1:0]              bus_state_reg;
    reg  [1:0]              bus_state_next;
    reg                     ch1_end_reg;
    reg                     ch2_end_reg;
    reg  [`RTPG_NCO_W-1:0]  nco_reg;
    reg  [`RTPG_NCO_W:0]    nco_sum;
    reg                     tick_reg;
    reg  [7:0]              rd_mux;
    reg  [7:0]              status_view;

    wire                    ch1_done;
    wire                    ch2_done;
    wire                    bus_ack    = (bus_state_reg == BUS_ACK);
    wire                    req        = avs_read || avs_write;
    wire                    wr_take    = avs_write && bus_ack && avs_byteenable[0];
    wire                    stat_clr   = avs_read && !bus_ack &&
                                         hit(avs_address, `RTPG_IDX_STATUS);
    wire                    ch1_run    = clk_on_reg && ch1_en_reg;
    wire                    ch2_run    = clk_on_reg && ch2_en_reg;

    // ======================================================================
    // Bus handshake
    // ======================================================================
    // One wait cycle: read data is registered in the first cycle and stands
    // in the second, where waitrequest drops.
    assign avs_waitrequest = req && !bus_ack;

    // A request held past its acknowledge starts a fresh access, so a
    // master that keeps read or write up sees every other cycle stalled.
    always @* begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (req) begin
                    bus_state_next = BUS_ACK;
                end
            end
            BUS_ACK: begin
                bus_state_next = BUS_IDLE;
            end
            default: begin
                // Illegal codes fall back to idle
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bus_state_reg <= BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // ======================================================================
    // Register writes
    // ======================================================================
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clk_on_reg           <= 1'b0;
            ch1_en_reg           <= 1'b0;
            ch1_vol_reg          <= 5'h00;
            channel1_divisor_reg <= `RTPG_RST_FREQUENCY;
            ch2_en_reg           <= 1'b0;
            ch2_vol_reg          <= 5'h00;
            channel2_divisor_reg <= `RTPG_RST_FREQUENCY;
        end else if (wr_take) begin
            if (hit(avs_address, `RTPG_IDX_CLOCK_GATE)) begin
                clk_on_reg <= avs_writedata[`RTPG_CLK_ON_BIT];
            end else if (hit(avs_address, `RTPG_IDX_CH1_CONTROL)) begin
                ch1_vol_reg <= avs_writedata[`RTPG_VOL_MSB:`RTPG_VOL_LSB];
                if (clk_on_reg) begin
                    ch1_en_reg <= avs_writedata[`RTPG_TONE_ON_BIT];
                end
            end else if (hit(avs_address, `RTPG_IDX_CH1_FREQUENCY)) begin
                channel1_divisor_reg <= avs_writedata[7:0];
            end else if (hit(avs_address, `RTPG_IDX_CH2_CONTROL)) begin
                ch2_vol_reg <= avs_writedata[`RTPG_VOL_MSB:`RTPG_VOL_LSB];
                if (clk_on_reg) begin
                    ch2_en_reg <= avs_writedata[`RTPG_TONE_ON_BIT];
                end
            end else if (hit(avs_address, `RTPG_IDX_CH2_FREQUENCY)) begin
                channel2_divisor_reg <= avs_writedata[7:0];
            end
        end
    end

    // ======================================================================
    // Register reads
    // ======================================================================
    always @* begin
        status_view = 8'h00;
        status_view[`RTPG_STAT_CH1_PWM_BIT] = tone1_pwm;
        status_view[`RTPG_STAT_CH2_PWM_BIT] = tone2_pwm;
        status_view[`RTPG_STAT_CH1_RUN_BIT] = ch1_run;
        status_view[`RTPG_STAT_CH2_RUN_BIT] = ch2_run;
        status_view[`RTPG_STAT_RING_BIT]    = ring_on;
        status_view[`RTPG_STAT_CH1_END_BIT] = ch1_end_reg;
        status_view[`RTPG_STAT_CH2_END_BIT] = ch2_end_reg;
        status_view[`RTPG_STAT_CLK_BIT]     = clk_on_reg;
    end

    always @* begin
        if (hit(avs_address, `RTPG_IDX_CLOCK_GATE)) begin
            rd_mux = {clk_on_reg, 7'h00};
        end else if (hit(avs_address, `RTPG_IDX_CH1_CONTROL)) begin
            rd_mux = ctl_view(ch1_en_reg, ch1_vol_reg);
        end else if (hit(avs_address, `RTPG_IDX_CH1_FREQUENCY)) begin
            rd_mux = channel1_divisor_reg;
        end else if (hit(avs_address, `RTPG_IDX_CH2_CONTROL)) begin
            rd_mux = ctl_view(ch2_en_reg, ch2_vol_reg);
        end else if (hit(avs_address, `RTPG_IDX_CH2_FREQUENCY)) begin
            rd_mux = channel2_divisor_reg;
        end else if (hit(avs_address, `RTPG_IDX_STATUS)) begin
            rd_mux = status_view;
        end else begin
            // Unmapped addresses read as zero
            rd_mux = 8'h00;
        end
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !bus_ack) begin
            avs_readdata <= {24'h00_0000, rd_mux};
        end
    end

    // ======================================================================
    // 768 kHz tick source
    // ======================================================================
    // The 12.288 MHz reference over 16 is synthesised by a phase accumulator,
    // exact on average; single ticks jitter by one system clock.
    always @* begin
        nco_sum = {1'b0, nco_reg} + {1'b0, NCO_INC};
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            nco_reg  <= {`RTPG_NCO_W{1'b0}};
            tick_reg <= 1'b0;
        end else if (!clk_on_reg) begin
            nco_reg  <= {`RTPG_NCO_W{1'b0}};
            tick_reg <= 1'b0;
        end else if (nco_sum >= {1'b0, NCO_WRAP}) begin
            nco_reg  <= nco_sum[`RTPG_NCO_W-1:0] - NCO_WRAP;
            tick_reg <= 1'b1;
        end else begin
            nco_reg  <= nco_sum[`RTPG_NCO_W-1:0];
            tick_reg <= 1'b0;
        end
    end

    // ======================================================================
    // Tone channels
    // ======================================================================
    rtpg_tone_chan u_chan1 (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .run         (ch1_run),
        .tick        (tick_reg),
        .divisor     (channel1_divisor_reg),
        .volume      (ch1_vol_reg),
        .pwm_out     (tone1_pwm),
        .period_done (ch1_done)
    );

    rtpg_tone_chan u_chan2 (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .run         (ch2_run),
        .tick        (tick_reg),
        .divisor     (channel2_divisor_reg),
        .volume      (ch2_vol_reg),
        .pwm_out     (tone2_pwm),
        .period_done (ch2_done)
    );

    // ======================================================================
    // Period-end flags
    // ======================================================================
    // Sticky per channel, so software can time the zero-volume period it
    // plays before a disable. A status read clears them at the edge that
    // captures the read data; a period end at that same edge wins, so no
    // end is lost between the capture and the clear.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ch1_end_reg <= 1'b0;
            ch2_end_reg <= 1'b0;
        end else begin
            if (ch1_done) begin
                ch1_end_reg <= 1'b1;
            end else if (stat_clr) begin
                ch1_end_reg <= 1'b0;
            end
            if (ch2_done) begin
                ch2_end_reg <= 1'b1;
            end else if (stat_clr) begin
                ch2_end_reg <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Mix toward the speakerphone driver
    // ======================================================================
    // A zero-volume period before disable is left to software, which can
    // time it with the period-end flags in the status register.
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tone_mix <= 2'b00;
        end else if (ring_on) begin
            tone_mix <= {1'b0, tone1_pwm} + {1'b0, tone2_pwm};
        end else begin
            tone_mix <= 2'b00;
        end
    end

endmodule // rtpg_top

// >>> logic/rtpg_regs.vh
// Constants for the ringer tone PWM generator: register indices, field
// positions, reset values and tone timing.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM register port.
`ifndef RTPG_REGS_VH
`define RTPG_REGS_VH

// ==========================================================================
// Register indices (byte address = index * 4)
// ==========================================================================
`define RTPG_IDX_CLOCK_GATE     12'h1a0
`define RTPG_IDX_CH1_CONTROL    12'h1a2
`define RTPG_IDX_CH1_FREQUENCY  12'h1a3
`define RTPG_IDX_CH2_CONTROL    12'h1a4
`define RTPG_IDX_CH2_FREQUENCY  12'h1a5
`define RTPG_IDX_STATUS         12'h1a6

// ==========================================================================
// Field positions
// ==========================================================================
`define RTPG_CLK_ON_BIT         7
`define RTPG_TONE_ON_BIT        7
`define RTPG_VOL_MSB            4
`define RTPG_VOL_LSB            0
`define RTPG_STAT_CH1_PWM_BIT   0
`define RTPG_STAT_CH2_PWM_BIT   1
`define RTPG_STAT_CH1_RUN_BIT   2
`define RTPG_STAT_CH2_RUN_BIT   3
`define RTPG_STAT_RING_BIT      4
`define RTPG_STAT_CH1_END_BIT   5
`define RTPG_STAT_CH2_END_BIT   6
`define RTPG_STAT_CLK_BIT       7

// ==========================================================================
// Reset values
// ==========================================================================
`define RTPG_RST_CLOCK_GATE     8'h00
`define RTPG_RST_CONTROL        8'h00
`define RTPG_RST_FREQUENCY      8'h00

// ==========================================================================
// Tone timing
// ==========================================================================
`define RTPG_SYS_HZ             125000000
`define RTPG_REF_HZ             12288000
`define RTPG_REF_DIV            16
`define RTPG_TICK_HZ            (`RTPG_REF_HZ / `RTPG_REF_DIV)
`define RTPG_STEPS              32
`define RTPG_NCO_W              27

`endif

// >>> logic/rtpg_tone_chan.v
// One tone channel: divides the 768 kHz tick by (divisor + 1) into 32 steps
// and forms a PWM waveform whose duty is volume/32.
// Assumes the tick is a one-cycle pulse in the ref_clk domain.
`timescale 1ns/1ps
`include "rtpg_regs.vh"

module rtpg_tone_chan (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       resetn,
    // Control
    input  wire       run,
    input  wire       tick,
    input  wire [7:0] divisor,
    input  wire [4:0] volume,
    // Waveform
    output reg        pwm_out,
    output reg        period_done
);

    reg  [7:0] presc_reg;
    reg  [4:0] step_reg;
    wire       step_adv = tick && (presc_reg == divisor);

    // ======================================================================
    // Step and prescale counters
    // ======================================================================
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            presc_reg   <= 8'h00;
            step_reg    <= 5'h00;
            period_done <= 1'b0;
        end else if (!run) begin
            // Stopped channel restarts from a clean period
            presc_reg   <= 8'h00;
            step_reg    <= 5'h00;
            period_done <= 1'b0;
        end else begin
            period_done <= step_adv && (step_reg == 5'h1f);
            if (step_adv) begin
                presc_reg <= 8'h00;
                step_reg  <= step_reg + 5'h01;
            end else if (tick) begin
                presc_reg <= presc_reg + 8'h01;
            end
        end
    end

    // ======================================================================
    // PWM output, high for the first volume steps of each period
    // ======================================================================
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pwm_out <= 1'b0;
        end else if (!run || (volume == 5'h00)) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (step_reg < volume);
        end
    end

endmodule // rtpg_tone_chan

// >>> tb/rtpg_monitor.sv
// Port checker for the ringer tone PWM generator.
// Assumes one ref_clk domain; bound to rtpg_top at the foot of this file.
`timescale 1ns/1ps
module rtpg_monitor (
    // Clock and reset
    input wire        ref_clk,
    input wire        resetn,
    // Register bus
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // Tone side
    input wire        ring_on,
    input wire        tone1_pwm,
    input wire        tone2_pwm,
    input wire [1:0]  tone_mix
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire req = avs_read | avs_write;
    // =====================================
    // Bus handshake
    sequence s_new_req; req && !$past(req); endsequence
    sequence s_ack; !avs_waitrequest; endsequence
    property p_wait_first; s_new_req |-> avs_waitrequest; endproperty
    property p_wait_one; req && avs_waitrequest |=> s_ack; endproperty
    property p_idle; !req |-> !avs_waitrequest; endproperty
    // Read data only moves at the edge that captures a read
    property p_rd_hold; !(avs_read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
    property p_rd_upper; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("new request not stalled");
    a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
    a_idle: assert property (p_idle) else $error("wait raised while idle");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
    // =====================================
    // Tone mix and pulse widths
    property p_mix_sum;
        ring_on |=> tone_mix == {1'b0, $past(tone1_pwm)} + {1'b0, $past(tone2_pwm)};
    endproperty
    property p_mix_quiet; !ring_on |=> tone_mix == 2'h0; endproperty
    // One volume step lasts well over 8 cycles, so no pulse may be shorter
    property p_t1_hi; $rose(tone1_pwm) |=> tone1_pwm [*8]; endproperty
    property p_t1_lo; $fell(tone1_pwm) |=> !tone1_pwm [*8]; endproperty
    property p_t2_hi; $rose(tone2_pwm) |=> tone2_pwm [*8]; endproperty
    a_mix_sum: assert property (p_mix_sum) else $error("mix is not the sum");
    a_mix_quiet: assert property (p_mix_quiet) else $error("mix active off ring");
    a_t1_hi: assert property (p_t1_hi) else $error("tone1 pulse too short");
    a_t1_lo: assert property (p_t1_lo) else $error("tone1 gap too short");
    a_t2_hi: assert property (p_t2_hi) else $error("tone2 pulse too short");
endmodule // rtpg_monitor

bind rtpg_top rtpg_monitor u_mon (.ref_clk(ref_clk), .resetn(resetn), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ring_on(ring_on), .tone1_pwm(tone1_pwm), .tone2_pwm(tone2_pwm), .tone_mix(tone_mix));

// >>> tb/rtpg_spk_model.sv
// Speakerphone driver stand-in: integrates the mixed tone drive level.
// Assumes tone_mix is registered in the ref_clk domain.
`timescale 1ns/1ps
module rtpg_spk_model (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        resetn,
    // Drive in, energy out
    input  wire [1:0]  tone_mix,
    output reg  [31:0] energy
);
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            energy <= 32'h0;
        else
            energy <= energy + {30'h0, tone_mix};
    end
endmodule // rtpg_spk_model

// >>> tb/tb_rtpg_top.sv
// Self-checking bench for the ringer tone PWM generator.
// Assumes rtpg_top, its header and the speaker model are compiled first.
`timescale 1ns/1ps
`include "rtpg_regs.vh"
module tb_rtpg_top;
    reg         ref_clk = 1'b0;
    reg         resetn = 1'b0;
    reg  [13:0] avs_address = 14'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    reg  [3:0]  avs_byteenable = 4'hf;
    reg         ring_on = 1'b0;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    wire        tone1_pwm;
    wire        tone2_pwm;
    wire [1:0]  tone_mix;
    wire [31:0] energy;
    int         errors = 0;
    int         compares = 0;
    real        cpt = 1.0 * `RTPG_SYS_HZ / `RTPG_TICK_HZ;

    always #4 ref_clk = ~ref_clk;

    rtpg_top DUT (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ring_on(ring_on), .tone1_pwm(tone1_pwm),
        .tone2_pwm(tone2_pwm), .tone_mix(tone_mix));
    rtpg_spk_model u_spk (.ref_clk(ref_clk), .resetn(resetn), .tone_mix(tone_mix),
        .energy(energy));

    // =====================================
    // Helpers
    task automatic test_done;
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Tick spacing varies between 162 and 163 cycles, so timings allow a few cycles
    task automatic near(input int got, input real exp);
        int e;
        e = $rtoi(exp + 0.5);
        check(got, (got >= e - 3 && got <= e + 3) ? got : e);
    endtask
    task automatic bus(input bit wr, input [11:0] i, input [7:0] d, input [3:0] be,
                       output [7:0] q);
        avs_address <= {i, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input [11:0] i, input [7:0] d);
        logic [7:0] q;
        bus(1'b1, i, d, 4'hf, q);
    endtask
    task automatic rd(input [11:0] i, output [7:0] q);
        bus(1'b0, i, 8'h0, 4'hf, q);
    endtask
    function automatic logic pwm(input bit ch);
        return ch ? tone2_pwm : tone1_pwm;
    endfunction
    // One full period from a rising edge; outputs sampled mid-cycle
    task automatic measure(input bit ch, output int hi, output int per, output int en);
        hi = 0;
        per = 0;
        do @(negedge ref_clk); while (pwm(ch) !== 1'b0);
        do @(negedge ref_clk); while (pwm(ch) !== 1'b1);
        en = energy;
        while (pwm(ch) === 1'b1) begin hi++; per++; @(negedge ref_clk); end
        while (pwm(ch) === 1'b0) begin per++; @(negedge ref_clk); end
        en = energy - en;
        @(posedge ref_clk);
    endtask
    task automatic quiet(input bit ch);
        int k;
        k = 0;
        repeat (6000) begin @(negedge ref_clk); k += (pwm(ch) !== 1'b0); end
        check(k, 0);
        @(posedge ref_clk);
    endtask

    // =====================================
    // Scenarios
    task automatic t_regs;
        logic [11:0] idx [5] = '{`RTPG_IDX_CLOCK_GATE, `RTPG_IDX_CH1_CONTROL,
            `RTPG_IDX_CH1_FREQUENCY, `RTPG_IDX_CH2_CONTROL, `RTPG_IDX_CH2_FREQUENCY};
        logic [7:0] q;
        foreach (idx[n]) begin rd(idx[n], q); check(q, 8'h00); end
        wr(12'h1a1, 8'hff);
        rd(12'h1a1, q); check(q, 8'h00);
        bus(1'b1, `RTPG_IDX_CH1_FREQUENCY, 8'h55, 4'he, q);
        rd(`RTPG_IDX_CH1_FREQUENCY, q); check(q, 8'h00);
        wr(`RTPG_IDX_CH2_FREQUENCY, 8'ha5);
        rd(`RTPG_IDX_CH2_FREQUENCY, q); check(q, 8'ha5);
    endtask
    task automatic t_gate;
        logic [7:0] q;
        wr(`RTPG_IDX_CH1_CONTROL, 8'h88);
        rd(`RTPG_IDX_CH1_CONTROL, q); check(q, 8'h08);
        wr(`RTPG_IDX_CLOCK_GATE, 8'h80);
        rd(`RTPG_IDX_CLOCK_GATE, q); check(q, 8'h80);
        quiet(1'b0);
    endtask
    task automatic t_tone;
        int hi, per, en;
        ring_on <= 1'b1;
        wr(`RTPG_IDX_CH2_FREQUENCY, 8'h00);
        wr(`RTPG_IDX_CH1_CONTROL, 8'h88);
        measure(1'b0, hi, per, en);
        near(per, 32.0 * cpt);
        near(hi, 8.0 * cpt);
        near(en, 8.0 * cpt);
        wr(`RTPG_IDX_CH2_CONTROL, 8'h9f);
        measure(1'b0, hi, per, en);
        near(en, 39.0 * cpt);
        ring_on <= 1'b0;
        measure(1'b0, hi, per, en);
        check(en, 0);
        wr(`RTPG_IDX_CH2_CONTROL, 8'h1f);
        wr(`RTPG_IDX_CH2_FREQUENCY, 8'h01);
        wr(`RTPG_IDX_CH2_CONTROL, 8'h9f);
        measure(1'b1, hi, per, en);
        near(per, 64.0 * cpt);
        near(hi, 62.0 * cpt);
    endtask
    task automatic t_mute;
        logic [7:0] q;
        wr(`RTPG_IDX_CH1_CONTROL, 8'h80);
        quiet(1'b0);
        wr(`RTPG_IDX_CH1_CONTROL, 8'h08);
        wr(`RTPG_IDX_CH2_CONTROL, 8'h1f);
        quiet(1'b1);
        wr(`RTPG_IDX_CLOCK_GATE, 8'h00);
        rd(`RTPG_IDX_CH2_CONTROL, q); check(q, 8'h1f);
    endtask

    initial begin
        repeat (95000) @(posedge ref_clk);
        errors++;
        test_done;
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_regs;
        t_gate;
        t_tone;
        t_mute;
        test_done;
    end
endmodule // tb_rtpg_top
